// >>> design/tmw_pkg.sv
// Package for the 8-bit timer waveform block: register map, fields, modes, state.
// Assumes a single 40 MHz clock domain shared with the APB master and prescaler.
package tmw_pkg;

    // Clock figure, kept for reference by derived timing
    localparam int unsigned CLK_PERIOD_NS = 25;

    // APB register byte addresses
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_COUNT = 8'h04;
    localparam logic [7:0] ADDR_CMP   = 8'h08;
    localparam logic [7:0] ADDR_FLAGS = 8'h0C;

    // Control register fields
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_COM_LSB  = 2;
    localparam int unsigned CTRL_DDR_BIT  = 4;
    localparam int unsigned CTRL_FORCE_BIT = 7;

    // Flag register fields
    localparam int unsigned FLG_OVF_BIT = 0;
    localparam int unsigned FLG_CMF_BIT = 1;

    // Counter extremes
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX    = 8'hFF;
    localparam logic [7:0] CNT_STEP   = 8'h01;

    // Waveform mode codes
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_PHASE  = 2'b01,
        MODE_CLR    = 2'b10,
        MODE_FAST   = 2'b11
    } tmw_mode_t;

    // Compare output mode codes
    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR  = 2'h2;
    localparam logic [1:0] COM_SET    = 2'h3;

    // Whole state of the timer block
    typedef struct packed {
        logic [7:0]  count_value;
        logic [7:0]  compare_value;
        logic [7:0]  compare_buf;
        tmw_mode_t   waveform_mode_bits;
        logic [1:0]  compare_output_mode_bits;
        logic        ddr_out;
        logic        overflow_flag;
        logic        compare_match_flag;
        logic        compare_output;
        logic        match_block;
        logic        pin_out;
        logic        pin_oe_n;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } tmw_state_t;

    // Reset leaves the pin undriven, since the direction is input then; all else is zero
    localparam tmw_state_t STATE_RESET = '{
        waveform_mode_bits: MODE_NORMAL,
        pin_oe_n:           1'b1,
        default:            '0
    };

endpackage

// >>> design/tmw_timer.sv
// 8-bit timer/counter with one compare channel: normal, clear-on-match, fast PWM.
// Assumes an APB master, a prescaler tick and interrupt service strobes on mclk.
//
// Summary of operation
// - Only the mode bits shape counting; compare output bits only shape the pin.
// - Normal mode counts up, never clears, wraps 0xFF to 0x00.
// - Normal mode raises overflow flag on the tick the count becomes zero.
// - Counting only sets overflow flag; interrupt service clears it.
// - Normal mode accepts a count write at any time.
// - Clear-on-match mode zeroes the count when it equals compare value.
// - Clear-on-match mode sets compare match flag at each top.
// - Clear-on-match mode writes compare value directly, no buffering.
// - Compare below count is missed until count wraps past 0xFF.
// - Clear-on-match with output mode 1 toggles output each match.
// - Pin shows compare output only when its direction is output.
// - Output frequency is clock over 2 times prescale times one plus compare.
// - Clear-on-match sets overflow flag when count rolls max to 0x00, not when a compare of 0xFF clears it.
// - Fast PWM counts bottom to max then restarts at bottom.
// - Fast PWM non-inverting clears on match, sets at bottom; inverting opposite.
// - Fast PWM clears the count on the tick after max.
// - Fast PWM sets overflow flag each time count leaves max for bottom.
// - Output bits pick polarity in PWM, set/clear/toggle otherwise.
// - Match sets compare flag on next tick; writing one clears it.
// - Fast PWM buffers compare value until bottom; other modes write directly.
`timescale 1ns/1ps
`default_nettype none

module tmw_timer
    import tmw_pkg::*;
(
    input  wire logic        mclk,         // 40 MHz clock
    input  wire logic        nrst,         // Asynchronous reset, active low
    input  wire logic        ce,           // Clock enable, freezes all state when low
    input  wire logic        tick,         // Timer clock enable from prescaler
    input  wire logic        ovf_serviced, // Overflow interrupt taken, one cycle
    input  wire logic        cmf_serviced, // Compare interrupt taken, one cycle
    input  wire logic        psel,         // APB select
    input  wire logic        penable,      // APB enable
    input  wire logic        pwrite,       // APB direction
    input  wire logic [7:0]  paddr,        // APB byte address
    input  wire logic [31:0] pwdata,       // APB write data
    output logic [31:0]      prdata,       // APB read data
    output logic             pready,       // APB ready
    output logic             pslverr,      // APB error on unmapped address
    output logic             overflow_flag,      // Overflow flag level
    output logic             compare_match_flag, // Compare match flag level
    output logic             pin_out,      // Port pin drive value
    output logic             pin_oe_n      // Port pin enable, low while driving
);

    tmw_state_t s_r;
    tmw_state_t s_nxt;

    // Bus decode shared by next-state logic and checks
    logic       acc_edge;
    logic       wr_ctrl;
    logic       wr_count;
    logic       wr_cmp;
    logic       wr_flags;
    logic       mapped;
    logic       is_pwm;
    logic       match;
    logic       at_max;
    logic       step;

    assign acc_edge = psel & penable & s_r.pready;
    assign wr_ctrl  = acc_edge & pwrite & (paddr == ADDR_CTRL);
    assign wr_count = acc_edge & pwrite & (paddr == ADDR_COUNT);
    assign wr_cmp   = acc_edge & pwrite & (paddr == ADDR_CMP);
    assign wr_flags = acc_edge & pwrite & (paddr == ADDR_FLAGS);
    assign mapped   = (paddr == ADDR_CTRL) | (paddr == ADDR_COUNT)
                    | (paddr == ADDR_CMP) | (paddr == ADDR_FLAGS);
    // Phase correct mode is not built; it counts like normal mode here
    assign is_pwm   = (s_r.waveform_mode_bits == MODE_FAST);
    // A count write blocks the match in the following tick
    assign match    = (s_r.count_value == s_r.compare_value) & ~s_r.match_block;
    assign at_max   = (s_r.count_value == CNT_MAX);
    assign step     = tick;

    // Next state: counter, flags, waveform and bus slave in one place
    always_comb begin
        logic oc;
        logic set_ovf;
        logic set_cmf;
        oc      = s_r.compare_output;
        set_ovf = 1'b0;
        set_cmf = 1'b0;
        s_nxt   = s_r;

        // Counting sequence depends on mode bits only
        if (step) begin
            s_nxt.match_block = 1'b0;
            unique case (s_r.waveform_mode_bits)
                MODE_CLR: begin
                    if (match) begin
                        s_nxt.count_value = CNT_BOTTOM;
                    end else begin
                        s_nxt.count_value = s_r.count_value + CNT_STEP;
                    end
                end
                MODE_FAST: begin
                    if (at_max) begin
                        s_nxt.count_value = CNT_BOTTOM;
                    end else begin
                        s_nxt.count_value = s_r.count_value + CNT_STEP;
                    end
                end
                MODE_NORMAL, MODE_PHASE: begin
                    s_nxt.count_value = s_r.count_value + CNT_STEP;
                end
            endcase
            // Overflow on the tick that leaves max, in every built mode except a clear-on-match top at max
            if (at_max && !(s_r.waveform_mode_bits == MODE_CLR && match)) begin
                set_ovf = 1'b1;
            end
            if (match) begin
                set_cmf = 1'b1;
            end

            // Compare output action chosen by output mode bits
            if (is_pwm) begin
                if (match) begin
                    unique case (s_r.compare_output_mode_bits)
                        COM_TOGGLE: oc = ~oc;
                        COM_CLEAR:  oc = 1'b0;
                        COM_SET:    oc = 1'b1;
                        COM_OFF:    oc = oc;
                    endcase
                end
                // Bottom action wins so compare at max gives a steady level
                if (at_max) begin
                    if (s_r.compare_output_mode_bits == COM_CLEAR) begin
                        oc = 1'b1;
                    end else if (s_r.compare_output_mode_bits == COM_SET) begin
                        oc = 1'b0;
                    end
                    s_nxt.compare_value = s_r.compare_buf;
                end
            end else if (match) begin
                unique case (s_r.compare_output_mode_bits)
                    COM_TOGGLE: oc = ~oc;
                    COM_CLEAR:  oc = 1'b0;
                    COM_SET:    oc = 1'b1;
                    COM_OFF:    oc = oc;
                endcase
            end
        end

        // Control write; force strobe acts only outside PWM
        if (wr_ctrl) begin
            s_nxt.waveform_mode_bits =
                tmw_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
            s_nxt.compare_output_mode_bits = pwdata[CTRL_COM_LSB +: 2];
            s_nxt.ddr_out = pwdata[CTRL_DDR_BIT];
            if (pwdata[CTRL_FORCE_BIT] && !is_pwm) begin
                unique case (pwdata[CTRL_COM_LSB +: 2])
                    COM_TOGGLE: oc = ~s_r.compare_output;
                    COM_CLEAR:  oc = 1'b0;
                    COM_SET:    oc = 1'b1;
                    COM_OFF:    oc = oc;
                endcase
            end
        end
        s_nxt.compare_output = oc;

        // Count write overrides counting and blocks the next match
        if (wr_count) begin
            s_nxt.count_value = pwdata[7:0];
            s_nxt.match_block = 1'b1;
        end

        // Compare write: buffer in PWM, direct otherwise
        if (wr_cmp) begin
            s_nxt.compare_buf = pwdata[7:0];
            if (!is_pwm) begin
                s_nxt.compare_value = pwdata[7:0];
            end
        end

        // Flags: set wins over software or service clear
        if (set_ovf) begin
            s_nxt.overflow_flag = 1'b1;
        end else if (ovf_serviced || (wr_flags && pwdata[FLG_OVF_BIT])) begin
            s_nxt.overflow_flag = 1'b0;
        end
        if (set_cmf) begin
            s_nxt.compare_match_flag = 1'b1;
        end else if (cmf_serviced || (wr_flags && pwdata[FLG_CMF_BIT])) begin
            s_nxt.compare_match_flag = 1'b0;
        end

        // Pin follows compare output only while direction is output
        s_nxt.pin_out  = s_nxt.ddr_out & s_nxt.compare_output;
        s_nxt.pin_oe_n = ~s_nxt.ddr_out;

        // APB: ready comes one cycle after setup, reads sampled at setup
        s_nxt.pready  = psel & ~penable & ~s_r.pready;
        s_nxt.pslverr = psel & ~penable & ~s_r.pready & ~mapped;
        s_nxt.prdata  = '0;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                ADDR_CTRL: begin
                    s_nxt.prdata[CTRL_MODE_LSB +: 2] = s_r.waveform_mode_bits;
                    s_nxt.prdata[CTRL_COM_LSB +: 2]  = s_r.compare_output_mode_bits;
                    s_nxt.prdata[CTRL_DDR_BIT]       = s_r.ddr_out;
                end
                ADDR_COUNT: s_nxt.prdata[7:0] = s_r.count_value;
                ADDR_CMP:   s_nxt.prdata[7:0] = s_r.compare_buf;
                ADDR_FLAGS: begin
                    s_nxt.prdata[FLG_OVF_BIT] = s_r.overflow_flag;
                    s_nxt.prdata[FLG_CMF_BIT] = s_r.compare_match_flag;
                end
                default:    s_nxt.prdata = '0;
            endcase
        end
    end

    // State register; clock enable freezes everything, bus included
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_r <= STATE_RESET;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state flops
    assign prdata             = s_r.prdata;
    assign pready             = s_r.pready;
    assign pslverr            = s_r.pslverr;
    assign overflow_flag      = s_r.overflow_flag;
    assign compare_match_flag = s_r.compare_match_flag;
    assign pin_out            = s_r.pin_out;
    assign pin_oe_n           = s_r.pin_oe_n;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    // Helper: an advancing tick with no bus write to the count
    logic adv;
    assign adv = ce & step & ~wr_count;

    property p_norm_wrap;
        adv && s_r.waveform_mode_bits == MODE_NORMAL && at_max && !wr_ctrl
        |=> s_r.count_value == CNT_BOTTOM && s_r.overflow_flag;
    endproperty
    a_norm_wrap: assert property (p_norm_wrap)
        else $error("normal mode did not wrap with overflow");

    property p_ovf_hold;
        ce && s_r.overflow_flag && !ovf_serviced && !wr_flags |=> s_r.overflow_flag;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold)
        else $error("overflow flag cleared without service");

    property p_clr_clear;
        adv && s_r.waveform_mode_bits == MODE_CLR && match && !wr_ctrl
        |=> s_r.count_value == CNT_BOTTOM ##0 s_r.compare_match_flag;
    endproperty
    a_clr_clear: assert property (p_clr_clear)
        else $error("clear-on-match did not clear count and flag");

    property p_clr_direct;
        ce && wr_cmp && s_r.waveform_mode_bits == MODE_CLR
        |=> s_r.compare_value == $past(pwdata[7:0]);
    endproperty
    a_clr_direct: assert property (p_clr_direct)
        else $error("compare write not direct in clear-on-match");

    property p_clr_toggle;
        adv && s_r.waveform_mode_bits == MODE_CLR && match && !wr_ctrl
        && s_r.compare_output_mode_bits == COM_TOGGLE
        |=> s_r.compare_output != $past(s_r.compare_output);
    endproperty
    a_clr_toggle: assert property (p_clr_toggle)
        else $error("compare output did not toggle on match");

    property p_pin_gate;
        pin_out == (s_r.ddr_out & s_r.compare_output) && pin_oe_n == !s_r.ddr_out;
    endproperty
    a_pin_gate: assert property (p_pin_gate)
        else $error("pin not gated by direction");

    property p_fast_bottom;
        adv && is_pwm && at_max && !wr_ctrl
        && s_r.compare_output_mode_bits == COM_CLEAR
        |=> s_r.count_value == CNT_BOTTOM && s_r.compare_output
            && s_r.overflow_flag;
    endproperty
    a_fast_bottom: assert property (p_fast_bottom)
        else $error("fast PWM bottom handling wrong");

    property p_pwm_buffer;
        ce && is_pwm && !(step && at_max) && !wr_ctrl
        |=> $stable(s_r.compare_value);
    endproperty
    a_pwm_buffer: assert property (p_pwm_buffer)
        else $error("PWM compare value changed away from bottom");

    property p_no_tick;
        ce && !step && !wr_count |=> $stable(s_r.count_value);
    endproperty
    a_no_tick: assert property (p_no_tick)
        else $error("count moved without a timer tick");

    // Compare flag stays until serviced or written
    property p_cmf_hold;
        ce && s_r.compare_match_flag && !cmf_serviced && !wr_flags
        |=> s_r.compare_match_flag;
    endproperty
    a_cmf_hold: assert property (p_cmf_hold)
        else $error("compare flag cleared without service");

    // Writing one clears the compare flag unless a match sets it again
    property p_cmf_clear;
        ce && wr_flags && pwdata[FLG_CMF_BIT] && !(step && match)
        |=> !s_r.compare_match_flag;
    endproperty
    a_cmf_clear: assert property (p_cmf_clear)
        else $error("compare flag not cleared by write");

    // Service clears overflow when no rollover sets it in the same cycle
    property p_ovf_service;
        ce && ovf_serviced && !(step && at_max) |=> !s_r.overflow_flag;
    endproperty
    a_ovf_service: assert property (p_ovf_service)
        else $error("overflow flag not cleared by service");

    // Away from the top, clear-on-match only steps up, wrapping past max
    property p_clr_count;
        adv && s_r.waveform_mode_bits == MODE_CLR && !match && !wr_ctrl
        |=> s_r.count_value == $past(s_r.count_value) + CNT_STEP;
    endproperty
    a_clr_count: assert property (p_clr_count)
        else $error("clear-on-match count did not step");

    // A missed top lets the count roll over with an overflow
    property p_clr_roll;
        adv && s_r.waveform_mode_bits == MODE_CLR && at_max && !match && !wr_ctrl
        |=> s_r.count_value == CNT_BOTTOM && s_r.overflow_flag;
    endproperty
    a_clr_roll: assert property (p_clr_roll)
        else $error("clear-on-match rollover without overflow");

    // Inverting fast PWM clears the output at bottom
    property p_fast_invert;
        adv && is_pwm && at_max && !wr_ctrl
        && s_r.compare_output_mode_bits == COM_SET
        |=> s_r.count_value == CNT_BOTTOM && !s_r.compare_output;
    endproperty
    a_fast_invert: assert property (p_fast_invert)
        else $error("inverting fast PWM bottom level wrong");

    // Non-inverting fast PWM clears the output on a match below max
    property p_fast_match;
        adv && is_pwm && match && !at_max && !wr_ctrl
        && s_r.compare_output_mode_bits == COM_CLEAR
        |=> !s_r.compare_output;
    endproperty
    a_fast_match: assert property (p_fast_match)
        else $error("fast PWM match did not clear output");

    // Fast PWM is single slope: only up below max
    property p_fast_count;
        adv && is_pwm && !at_max && !wr_ctrl
        |=> s_r.count_value == $past(s_r.count_value) + CNT_STEP;
    endproperty
    a_fast_count: assert property (p_fast_count)
        else $error("fast PWM count did not step up");

    // Clock enable low freezes the whole state, bus slave included
    property p_freeze;
        !ce |=> $stable(s_r);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while clock enable low");

endmodule

`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the 8-bit timer: reset values, normal wrap, clear-on-match, fast PWM.
// Assumes tmw_timer with its APB slave answering one cycle after setup.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import tmw_pkg::*;

    logic        mclk, nrst, ce, tick, ovf_serviced, cmf_serviced;
    logic        psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, overflow_flag, compare_match_flag, pin_out, pin_oe_n, rd_err;
    int          error_cnt, checks;

    tmw_timer uut (
        .mclk              (mclk),
        .nrst              (nrst),
        .ce                (ce),
        .tick              (tick),
        .ovf_serviced      (ovf_serviced),
        .cmf_serviced      (cmf_serviced),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .overflow_flag     (overflow_flag),
        .compare_match_flag(compare_match_flag),
        .pin_out           (pin_out),
        .pin_oe_n          (pin_oe_n)
    );

    // 25 ns clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // One compare for every kind of result
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk("pready", 1, 0);
        rd      = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Timer clock enable held high for n edges, then outputs settle
    task automatic ticks(input int n);
        @(posedge mclk);
        tick <= 1'b1;
        repeat (n) @(posedge mclk);
        tick <= 1'b0;
        #1;
    endtask

    task automatic ctrl(input logic [1:0] mode, input logic [1:0] com, input logic ddr);
        apb(1'b1, ADDR_CTRL, {27'h0, ddr, com, mode});
    endtask

    task automatic t_reset_values();
        apb(1'b0, ADDR_CTRL, 32'h0);  chk("ctrl", 32'h0, rd);
        apb(1'b0, ADDR_COUNT, 32'h0); chk("count", 32'h0, rd);
        apb(1'b0, ADDR_FLAGS, 32'h0); chk("flags", 32'h0, rd);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, rd_err});
        chk("unmapped data", 32'h0, rd);
        chk("pin hidden", 32'h1, {31'h0, pin_oe_n});
    endtask

    task automatic t_normal_wrap();
        ctrl(2'h0, COM_OFF, 1'b0);
        apb(1'b1, ADDR_COUNT, 32'hFE);
        ticks(1);
        chk("ovf early", 32'h0, {31'h0, overflow_flag});
        ticks(1);
        chk("ovf wrap", 32'h1, {31'h0, overflow_flag});
        apb(1'b0, ADDR_COUNT, 32'h0); chk("count wrap", 32'h00, rd);
        ticks(3);
        chk("ovf held", 32'h1, {31'h0, overflow_flag});
        @(posedge mclk);
        ovf_serviced <= 1'b1;
        @(posedge mclk);
        ovf_serviced <= 1'b0;
        #1;
        chk("ovf serviced", 32'h0, {31'h0, overflow_flag});
    endtask

    task automatic t_clr_toggle();
        ctrl(MODE_CLR, COM_TOGGLE, 1'b1);
        apb(1'b1, ADDR_FLAGS, 32'h3);
        apb(1'b1, ADDR_CMP, 32'h03);
        apb(1'b1, ADDR_COUNT, 32'h00);
        ticks(3);
        chk("pin before match", 32'h0, {31'h0, pin_out});
        chk("cmf before", 32'h0, {31'h0, compare_match_flag});
        ticks(1);
        chk("pin toggled", 32'h1, {31'h0, pin_out});
        chk("pin driven", 32'h0, {31'h0, pin_oe_n});
        chk("cmf set", 32'h1, {31'h0, compare_match_flag});
        apb(1'b0, ADDR_COUNT, 32'h0); chk("count top clear", 32'h0, rd);
        apb(1'b1, ADDR_FLAGS, 32'h2);
        #1;
        chk("cmf cleared", 32'h0, {31'h0, compare_match_flag});
        ticks(4);
        chk("pin toggled back", 32'h0, {31'h0, pin_out});
        chk("ovf no roll", 32'h0, {31'h0, overflow_flag});
    endtask

    task automatic t_clr_missed();
        ctrl(MODE_CLR, COM_TOGGLE, 1'b0);
        apb(1'b1, ADDR_COUNT, 32'h10);
        apb(1'b1, ADDR_FLAGS, 32'h3);
        apb(1'b1, ADDR_CMP, 32'h05);
        ticks(240);
        chk("ovf roll", 32'h1, {31'h0, overflow_flag});
        chk("cmf missed", 32'h0, {31'h0, compare_match_flag});
        ticks(6);
        chk("cmf after wrap", 32'h1, {31'h0, compare_match_flag});
        apb(1'b0, ADDR_COUNT, 32'h0); chk("count after match", 32'h0, rd);
        chk("pin hidden", 32'h0, {31'h0, pin_out});
    endtask

    task automatic t_fast_pwm(input logic [1:0] com);
        logic inv;
        inv = (com == COM_SET);
        ctrl(MODE_CLR, com, 1'b1);
        apb(1'b1, ADDR_CMP, 32'h80);
        ctrl(MODE_FAST, com, 1'b1);
        apb(1'b1, ADDR_COUNT, 32'hFD);
        apb(1'b1, ADDR_FLAGS, 32'h3);
        ticks(2);
        apb(1'b0, ADDR_COUNT, 32'h0); chk("pwm max", 32'hFF, rd);
        ticks(1);
        apb(1'b0, ADDR_COUNT, 32'h0); chk("pwm bottom", 32'h00, rd);
        chk("pwm ovf", 32'h1, {31'h0, overflow_flag});
        chk("pwm bottom lvl", {31'h0, ~inv}, {31'h0, pin_out});
        ticks(128);
        chk("pwm before match", {31'h0, ~inv}, {31'h0, pin_out});
        ticks(1);
        chk("pwm after match", {31'h0, inv}, {31'h0, pin_out});
        apb(1'b0, ADDR_COUNT, 32'h0); chk("pwm no clear", 32'h81, rd);
    endtask

    // Service pulse, frozen clock enable, force strobe, unbuilt mode, reset in mid-run
    task automatic t_service_freeze();
        chk("cmf pwm", 32'h1, {31'h0, compare_match_flag});
        @(posedge mclk);
        cmf_serviced <= 1'b1;
        @(posedge mclk);
        cmf_serviced <= 1'b0;
        #1;
        chk("cmf serviced", 32'h0, {31'h0, compare_match_flag});
        @(posedge mclk);
        ce <= 1'b0;
        ticks(5);
        @(posedge mclk);
        ce <= 1'b1;
        apb(1'b0, ADDR_COUNT, 32'h0); chk("count frozen", 32'h81, rd);
        ctrl(2'h0, COM_OFF, 1'b1);
        apb(1'b1, ADDR_CTRL, 32'h98);
        #1;
        chk("force clear", 32'h0, {31'h0, pin_out});
        apb(1'b1, ADDR_CTRL, 32'h94);
        #1;
        chk("force toggle", 32'h1, {31'h0, pin_out});
        chk("force no flag", 32'h0, {31'h0, compare_match_flag});
        apb(1'b0, ADDR_CTRL, 32'h0); chk("ctrl readback", 32'h14, rd);
        ctrl(2'h1, COM_OFF, 1'b1);
        apb(1'b1, ADDR_FLAGS, 32'h3);
        apb(1'b1, ADDR_COUNT, 32'hFF);
        ticks(2);
        apb(1'b0, ADDR_COUNT, 32'h0); chk("mode one count", 32'h01, rd);
        chk("mode one ovf", 32'h1, {31'h0, overflow_flag});
        @(posedge mclk);
        nrst <= 1'b0;
        @(posedge mclk);
        #1;
        chk("reset ovf", 32'h0, {31'h0, overflow_flag});
        chk("reset pin", 32'h0, {31'h0, pin_out});
        chk("reset pin off", 32'h1, {31'h0, pin_oe_n});
        @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        apb(1'b0, ADDR_COUNT, 32'h0); chk("reset count", 32'h0, rd);
        apb(1'b0, ADDR_CTRL, 32'h0); chk("reset ctrl", 32'h0, rd);
    endtask

    // Hang guard, far beyond the expected run length
    initial begin
        #(25 * 20000);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        error_cnt    = 0;
        checks       = 0;
        nrst         = 1'b0;
        ce           = 1'b1;
        tick         = 1'b0;
        ovf_serviced = 1'b0;
        cmf_serviced = 1'b0;
        psel         = 1'b0;
        penable      = 1'b0;
        pwrite       = 1'b0;
        paddr        = 8'h00;
        pwdata       = 32'h0;
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        t_reset_values();
        t_normal_wrap();
        t_clr_toggle();
        t_clr_missed();
        t_fast_pwm(COM_CLEAR);
        t_fast_pwm(COM_SET);
        t_service_freeze();
        report_and_stop();
    end

endmodule

`default_nettype wire
